/* File: pco_top.sv */
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "pco_map.svh"

// Summary of operation
// - Clock pin is shared with general I/O; enable bit picks the clock function.
// - Clock source is timer zero match rate halved, or the system clock, undivided or divided.
// - Enable bit written 1 turns the clock output on, 0 turns it off.
// - Two-bit divider select at control bits 3 and 2 picks the frequency.
// - Sleep mode stops the clock output regardless of the enable bit.
// - Control: serial mode 7..5 resets ones; enable, select, serial enable reset zero.
// - Select 00 system clock, 01 by four, 10 by eight, 11 timer half.
module pco_top import pco_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic sleepMode,
  input wire logic periodCompareMatch,
  input wire logic periphClockPinIn,
  output logic periphClockPinOut,
  output logic periphClockPinOe
);

  localparam logic [7:0] ADDR_CTRL = `PCO_ADDR_CTRL;
  localparam logic [7:0] ADDR_GPIO = `PCO_ADDR_GPIO;
  localparam logic [7:0] ADDR_STAT = `PCO_ADDR_STAT;

  // Write channel state
  logic awHave_q;
  logic awHave_d;
  logic wHave_q;
  logic wHave_d;
  logic [7:0] awAddr_q;
  logic [7:0] wData_q;
  logic wStrb0_q;
  logic bValid_d;
  logic [1:0] bResp_d;
  logic awReady_d;
  logic wReady_d;

  // Read channel state
  logic rValid_d;
  logic arReady_d;
  logic [31:0] rData_d;
  logic [1:0] rResp_d;

  // Registers
  logic [7:0] serialAndClockOutControl_q;
  logic [7:0] serialAndClockOutControl_d;
  logic [1:0] gpio_q;
  logic [1:0] gpio_d;

  // Clock generator state
  pco_state_t state_q;
  pco_state_t state_d;
  pco_sel_t activeSel_q;
  pco_sel_t activeSel_d;
  logic gateFall_q;
  logic useGate_q;
  logic pinOut_q;
  logic pinOut_d;
  logic pinOe_d;
  logic lvlDiv4;
  logic lvlDiv8;
  logic lvlTmr;

  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire arFire = s_axi_arvalid && s_axi_arready;

  wire wrIsCtrl = (awAddr_q[7:2] == ADDR_CTRL[7:2]);
  wire wrIsGpio = (awAddr_q[7:2] == ADDR_GPIO[7:2]);
  wire wrIsStat = (awAddr_q[7:2] == ADDR_STAT[7:2]);
  wire wrHit = wrIsCtrl || wrIsGpio || wrIsStat;
  wire wrCtrl = doWrite && wrIsCtrl && wStrb0_q;
  wire wrGpio = doWrite && wrIsGpio && wStrb0_q;

  wire rdIsCtrl = (s_axi_araddr[7:2] == ADDR_CTRL[7:2]);
  wire rdIsGpio = (s_axi_araddr[7:2] == ADDR_GPIO[7:2]);
  wire rdIsStat = (s_axi_araddr[7:2] == ADDR_STAT[7:2]);

  assign awHave_d = awFire || (awHave_q && !doWrite);
  assign wHave_d = wFire || (wHave_q && !doWrite);
  assign bValid_d = doWrite || (s_axi_bvalid && !s_axi_bready);
  assign bResp_d = doWrite ? (wrHit ? `PCO_RESP_OKAY : `PCO_RESP_DECERR) : s_axi_bresp;
  assign awReady_d = !awHave_d && !bValid_d;
  assign wReady_d = !wHave_d && !bValid_d;

  assign rValid_d = arFire || (s_axi_rvalid && !s_axi_rready);
  assign arReady_d = !rValid_d;

  // Serial fields are kept but have no effect here; bit 0 reads zero
  assign serialAndClockOutControl_d = wrCtrl ? (wData_q & `PCO_CTRL_WMASK) : serialAndClockOutControl_q;
  assign gpio_d = wrGpio ? wData_q[1:0] : gpio_q;

  // Mnemonic views of the control and GPIO registers
  wire periphClockOutEnable = serialAndClockOutControl_q[`PCO_OE_BIT];
  wire periphClockDivSelHi = serialAndClockOutControl_q[`PCO_SEL_HI];
  wire periphClockDivSelLo = serialAndClockOutControl_q[`PCO_SEL_LO];
  wire [2:0] serialModeSel = serialAndClockOutControl_q[`PCO_SMODE_HI:`PCO_SMODE_LO];
  wire serialIfaceOn = serialAndClockOutControl_q[`PCO_SIEN_BIT];
  wire gpioData = gpio_q[`PCO_GPIO_DATA_BIT];
  wire gpioDir = gpio_q[`PCO_GPIO_DIR_BIT];

  wire [7:0] statusWord = {2'b00, periphClockPinIn, sleepMode, activeSel_q,
                           state_q == PCO_STOP, state_q == PCO_RUN};

  assign rData_d = !arFire ? s_axi_rdata :
                   rdIsCtrl ? {24'h000000, serialModeSel, periphClockOutEnable, periphClockDivSelHi,
                               periphClockDivSelLo, serialIfaceOn, 1'b0} :
                   rdIsGpio ? {30'h0, gpio_q} :
                   rdIsStat ? {24'h000000, statusWord} : 32'h00000000;
  assign rResp_d = !arFire ? s_axi_rresp :
                   (rdIsCtrl || rdIsGpio || rdIsStat) ? `PCO_RESP_OKAY : `PCO_RESP_DECERR;

  // Clock generator control
  wire wantClock = periphClockOutEnable && !sleepMode;
  pco_sel_t selField;
  assign selField = pco_sel_t'({periphClockDivSelHi, periphClockDivSelLo});
  wire activeLevel = (activeSel_q == PCO_SEL_SYS) ? gateFall_q :
                     (activeSel_q == PCO_SEL_DIV4) ? lvlDiv4 :
                     (activeSel_q == PCO_SEL_DIV8) ? lvlDiv8 : lvlTmr;
  wire keepRun = (state_q == PCO_RUN) || ((state_q == PCO_STOP) && activeLevel);
  wire runDiv4 = keepRun && (activeSel_q == PCO_SEL_DIV4);
  wire runDiv8 = keepRun && (activeSel_q == PCO_SEL_DIV8);
  // Timer source stops at once: the next match may never come in sleep
  wire runTmr = (state_q == PCO_RUN) && (activeSel_q == PCO_SEL_TMR);
  wire runSys = (state_q == PCO_RUN) && (activeSel_q == PCO_SEL_SYS);
  wire srcLevel = (activeSel_q == PCO_SEL_DIV4) ? lvlDiv4 :
                  (activeSel_q == PCO_SEL_DIV8) ? lvlDiv8 :
                  (activeSel_q == PCO_SEL_TMR) ? lvlTmr : 1'b0;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PCO_IDLE:
        state_d = wantClock ? PCO_RUN : PCO_IDLE;
      PCO_RUN:
        state_d = (!wantClock || (selField != activeSel_q)) ? PCO_STOP : PCO_RUN;
      PCO_STOP:
        state_d = activeLevel ? PCO_STOP : PCO_IDLE;
      default:
        state_d = PCO_IDLE;
    endcase
  end

  // A new source is only taken up while the pin rests low
  assign activeSel_d = ((state_q == PCO_IDLE) && wantClock) ? selField : activeSel_q;
  assign pinOut_d = periphClockOutEnable ? srcLevel : gpioData;
  assign pinOe_d = periphClockOutEnable || gpioDir;

  pco_div #(.HALF(`PCO_DIV4_HALF)) u_div4 (
    .clk(clk),
    .rst(rst),
    .run(runDiv4),
    .tick(1'b1),
    .level(lvlDiv4)
  );

  pco_div #(.HALF(`PCO_DIV8_HALF)) u_div8 (
    .clk(clk),
    .rst(rst),
    .run(runDiv8),
    .tick(1'b1),
    .level(lvlDiv8)
  );

  pco_div #(.HALF(`PCO_TMR_HALF)) u_tmr (
    .clk(clk),
    .rst(rst),
    .run(runTmr),
    .tick(periodCompareMatch),
    .level(lvlTmr)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCO_RESP_OKAY;
    end
    else
    begin
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      s_axi_awready <= awReady_d;
      s_axi_wready <= wReady_d;
      s_axi_bvalid <= bValid_d;
      s_axi_bresp <= bResp_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (awFire)
      awAddr_q <= s_axi_awaddr;
    if (wFire)
    begin
      wData_q <= s_axi_wdata[7:0];
      wStrb0_q <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCO_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= arReady_d;
      s_axi_rvalid <= rValid_d;
      s_axi_rdata <= rData_d;
      s_axi_rresp <= rResp_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serialAndClockOutControl_q <= `PCO_CTRL_RST;
      gpio_q <= `PCO_GPIO_RST;
      state_q <= PCO_IDLE;
      activeSel_q <= PCO_SEL_SYS;
      pinOut_q <= 1'b0;
      periphClockPinOe <= 1'b0;
    end
    else
    begin
      serialAndClockOutControl_q <= serialAndClockOutControl_d;
      gpio_q <= gpio_d;
      state_q <= state_d;
      activeSel_q <= activeSel_d;
      pinOut_q <= pinOut_d;
      periphClockPinOe <= pinOe_d;
    end
  end

  // Gate and pin mux select change only while clk is low, so a switch never cuts a high phase
  always_ff @(negedge clk)
  begin
    if (rst)
    begin
      gateFall_q <= 1'b0;
      useGate_q <= 1'b0;
    end
    else
    begin
      gateFall_q <= runSys;
      useGate_q <= periphClockOutEnable && (activeSel_q == PCO_SEL_SYS);
    end
  end

  // Full-rate path passes clk through the low-phase gate
  assign periphClockPinOut = useGate_q ? (clk & gateFall_q) : pinOut_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ctrl_reset_a: assert property (disable iff (1'b0) rst |=> serialAndClockOutControl_q == `PCO_CTRL_RST)
    else $error("control register reset value wrong");

  pin_share_a: assert property (!periphClockOutEnable && !$past(periphClockOutEnable) |->
    periphClockPinOut == $past(gpioData) && periphClockPinOe == $past(gpioDir))
    else $error("pin not acting as plain I/O");

  on_off_a: assert property (!periphClockOutEnable [*8] |-> state_q == PCO_IDLE && !gateFall_q)
    else $error("clock still running while disabled");

  start_a: assert property (state_q == PCO_IDLE && wantClock |=> state_q == PCO_RUN && activeSel_q == $past(selField))
    else $error("clock did not start with selected source");

  sleep_stop_a: assert property (sleepMode [*8] |->
    (!pinOut_q || !$past(periphClockOutEnable)) && !gateFall_q && state_q == PCO_IDLE)
    else $error("clock output active during sleep");

  div4_rate_a: assert property ($rose(lvlDiv4) |-> lvlDiv4 [*2] ##1 !lvlDiv4)
    else $error("divide-by-four half period wrong");

  div8_rate_a: assert property ($rose(lvlDiv8) |-> lvlDiv8 [*4] ##1 !lvlDiv8)
    else $error("divide-by-eight half period wrong");

  timer_half_a: assert property (runTmr && periodCompareMatch |=> lvlTmr != $past(lvlTmr))
    else $error("timer source did not toggle on match");

  switch_clean_a: assert property (activeSel_q != $past(activeSel_q) |-> $past(state_q) == PCO_IDLE)
    else $error("source switched while clock active");

  select_map_a: assert property (state_q == PCO_RUN && selField == activeSel_q [*2] |-> ##[0:1]
    ((activeSel_q == PCO_SEL_SYS) == gateFall_q))
    else $error("divider select not followed");

  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  run_sys_c: cover property (state_q == PCO_RUN && activeSel_q == PCO_SEL_SYS && gateFall_q);
  run_div8_c: cover property ($rose(lvlDiv8) && state_q == PCO_RUN);
  run_tmr_c: cover property (runTmr && periodCompareMatch);
  sleep_stop_c: cover property (state_q == PCO_RUN && sleepMode ##1 state_q == PCO_STOP);

endmodule : pco_top

/* File: pco_map.svh */
`ifndef PCO_MAP_SVH
`define PCO_MAP_SVH

`define PCO_ADDR_CTRL 8'h00
`define PCO_ADDR_GPIO 8'h04
`define PCO_ADDR_STAT 8'h08

`define PCO_CTRL_RST 8'he0
`define PCO_CTRL_WMASK 8'hfe
`define PCO_SMODE_HI 7
`define PCO_SMODE_LO 5
`define PCO_OE_BIT 4
`define PCO_SEL_HI 3
`define PCO_SEL_LO 2
`define PCO_SIEN_BIT 1

`define PCO_GPIO_RST 2'b00
`define PCO_GPIO_DATA_BIT 0
`define PCO_GPIO_DIR_BIT 1

`define PCO_DIV4_HALF 2
`define PCO_DIV8_HALF 4
`define PCO_TMR_HALF 1
`define PCO_CNT_W 3

`define PCO_RESP_OKAY 2'b00
`define PCO_RESP_DECERR 2'b11

`endif

/* File: pco_pkg.sv */
package pco_pkg;

  typedef enum logic [2:0]
  {
    PCO_IDLE = 3'b001,
    PCO_RUN = 3'b010,
    PCO_STOP = 3'b100
  } pco_state_t;

  typedef enum logic [1:0]
  {
    PCO_SEL_SYS = 2'b00,
    PCO_SEL_DIV4 = 2'b01,
    PCO_SEL_DIV8 = 2'b10,
    PCO_SEL_TMR = 2'b11
  } pco_sel_t;

endpackage : pco_pkg

/* File: pco_div.sv */
`timescale 1ns/1ps
`include "pco_map.svh"

// Toggles its level every HALF ticks while run is high; cleared low otherwise
module pco_div #(
  parameter int HALF = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  output logic level
);

  logic [`PCO_CNT_W-1:0] cnt_q;
  logic [`PCO_CNT_W-1:0] cnt_d;
  logic level_d;
  wire wrap = (cnt_q == `PCO_CNT_W'(HALF - 1));

  assign cnt_d = !run ? '0 : !tick ? cnt_q : wrap ? '0 : cnt_q + `PCO_CNT_W'(1);
  assign level_d = !run ? 1'b0 : (tick && wrap) ? !level : level;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      level <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      level <= level_d;
    end
  end

endmodule : pco_div

/* File: pco_ext_model.sv */
`timescale 1ns/1ps
// Load clocked from the pin: counts rising edges and the shortest high pulse while the pin is driven
module pco_ext_model (
  input wire logic clk,
  input wire logic pin,
  input wire logic oe,
  input wire logic clr,
  output logic extDrive,
  output int edgeCnt,
  output int minHigh
);
  realtime tRise;
  initial extDrive = 1'b0;
  // A released pin shows a changing level, never the last driven one
  always @(posedge clk) extDrive <= ~extDrive;
  always @(posedge clr)
  begin
    edgeCnt = 0;
    minHigh = 1000000;
  end
  always @(posedge pin)
  begin
    if (oe)
    begin
      edgeCnt++;
      tRise = $realtime;
    end
  end
  always @(negedge pin)
  begin
    if (oe && $realtime - tRise < minHigh)
      minHigh = int'($realtime - tRise);
  end
endmodule : pco_ext_model

/* File: tb_peripheral_clock_output.sv */
`timescale 1ns/1ps
module tb_peripheral_clock_output import pco_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic sleepMode = 1'b0, periodCompareMatch = 1'b0, clr = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, g;
  logic [31:0] s_axi_rdata, rd, d;
  logic periphClockPinOut, periphClockPinOe, extDrive;
  wire pinLevel = periphClockPinOe ? periphClockPinOut : extDrive;
  int error_cnt = 0, cmp_count = 0, edgeCnt, minHigh, c0;

  initial forever #50 clk = ~clk;

  pco_top dut (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sleepMode, .periodCompareMatch,
    .periphClockPinIn(pinLevel), .periphClockPinOut, .periphClockPinOe);
  pco_ext_model ext (.clk, .pin(pinLevel), .oe(periphClockPinOe), .clr, .extDrive, .edgeCnt, .minHigh);

  task automatic report_and_stop();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk_val(string n, logic [31:0] e, logic [31:0] v);
    cmp_count++;
    if (v !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, v);
      error_cnt++;
    end
  endtask : chk_val

  task automatic chk_near(string n, int e, int v, int tol);
    cmp_count++;
    if (v < e - tol || v > e + tol)
    begin
      $display("MISMATCH %s expected %0d seen %0d", n, e, v);
      error_cnt++;
    end
  endtask : chk_near

  task automatic time_out(string n);
    $display("MISMATCH %s expected answer seen timeout", n);
    error_cnt++;
    report_and_stop();
  endtask : time_out

  task automatic axi_write(logic [7:0] a, logic [31:0] v);
    bit ta, tw, tb;
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 0;
    for (n = 0; n < 50 && !tb; n++)
    begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) time_out("bvalid");
  endtask : axi_write

  task automatic axi_read(logic [7:0] a);
    bit ta, tr;
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 0;
    for (n = 0; n < 50 && !tr; n++)
    begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) time_out("rvalid");
  endtask : axi_read

  // Drives one timer match pulse every e cycles, none when e is zero
  task automatic run_cyc(int n, int e);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      periodCompareMatch <= e > 0 && i % e == 0 && i < n - 1;
    end
  endtask : run_cyc

  function automatic int exp_edges(pco_sel_t s, int n, int e);
    case (s)
      PCO_SEL_SYS: return n;
      PCO_SEL_DIV4: return n / 4;
      PCO_SEL_DIV8: return n / 8;
      default: return n / e / 2;
    endcase
  endfunction : exp_edges

  task automatic count_edges(int e, int ex);
    run_cyc(20, e);
    c0 = edgeCnt;
    run_cyc(80, e);
    chk_near("edges", ex, edgeCnt - c0, 1);
  endtask : count_edges

  initial
  begin
    void'($urandom(24157));
    #1 clr = 1'b1;
    #1 clr = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    axi_read(8'h00);
    chk_val("ctrl reset", 32'he0, rd);
    repeat (4)
    begin
      d = $urandom;
      axi_write(8'h00, d);
      axi_read(8'h00);
      chk_val("ctrl", {24'h0, d[7:0] & 8'hfe}, rd);
    end
    s_axi_wstrb <= 4'h0;
    axi_write(8'h00, ~d);
    s_axi_wstrb <= 4'hf;
    chk_val("bresp strb", 2'b00, resp);
    axi_read(8'h00);
    chk_val("ctrl strb", {24'h0, d[7:0] & 8'hfe}, rd);
    axi_write(8'h0c, $urandom);
    chk_val("bresp", 2'b11, resp);
    axi_read(8'h0c);
    chk_val("rresp", 2'b11, resp);
    chk_val("rdata", 0, rd);
    axi_write(8'h00, 32'h0);
    repeat (4)
    begin
      g = 2'($urandom % 4);
      axi_write(8'h04, g);
      run_cyc(2, 0);
      chk_val("gpio pin", g[0], periphClockPinOut);
      chk_val("gpio oe", g[1], periphClockPinOe);
    end
    axi_write(8'h04, 32'h2);
    count_edges(0, 0);
    for (int s = 0; s < 4; s++)
      begin
        c0 = 2 + $urandom % 4;
        axi_write(8'h00, 32'h10 | (s << 2));
        count_edges(c0, exp_edges(pco_sel_t'(s), 80, c0));
      end
    axi_write(8'h00, 32'h14);
    run_cyc(10, 0);
    #1 clr = 1'b1;
    #1 clr = 1'b0;
    axi_write(8'h00, 32'h18);
    run_cyc(30, 0);
    axi_write(8'h00, 32'h14);
    run_cyc(30, 0);
    chk_val("min high", 1, minHigh >= 200);
    #1 clr = 1'b1;
    #1 clr = 1'b0;
    axi_write(8'h00, 32'h10);
    run_cyc(10, 0);
    axi_write(8'h00, 32'h0);
    run_cyc(4, 0);
    chk_val("sys min high", 1, minHigh >= 50);
    axi_write(8'h00, 32'h14);
    run_cyc(10, 0);
    @(posedge clk);
    sleepMode <= 1'b1;
    run_cyc(8, 0);
    count_edges(0, 0);
    chk_val("sleep pin", 0, periphClockPinOut);
    axi_read(8'h08);
    chk_val("status", 32'h14, rd);
    @(posedge clk);
    sleepMode <= 1'b0;
    count_edges(0, 20);
    axi_write(8'h00, 32'h04);
    count_edges(0, 0);
    chk_val("off pin", 0, periphClockPinOut);
    report_and_stop();
  end
endmodule : tb_peripheral_clock_output
